// *** src/pmsq_pkg.sv ***
// shared constants and types for the panel meter sequencer
// assumes a single 100 MHz clock; all long times are counted in 1 ms ticks
package pmsq_pkg;
   // ==========================================================
   // clock and tick divider
   localparam int CLK_MHZ = 100;
   localparam int TICK_TIME_US = 1000;
   localparam int TICK_CYCLES = TICK_TIME_US * CLK_MHZ;
   localparam int TICK_TIME_MS = TICK_TIME_US / 1000;
   localparam int TICK_DIV_W = 17;
   localparam int TICK_CNT_W = 13;

   // ==========================================================
   // sequence times in ms and their tick counts
   localparam int REF_WAIT_MS = 6000;
   localparam int ENH_CAL_MS = 2000;
   localparam int HOLD_CAL_MS = 2000;
   localparam int REFRESH_RATE_MHZ = 2500;
   localparam int REFRESH_MS = 1000000 / REFRESH_RATE_MHZ;
   localparam int REF_WAIT_TICKS = REF_WAIT_MS / TICK_TIME_MS;
   localparam int ENH_CAL_TICKS = ENH_CAL_MS / TICK_TIME_MS;
   localparam int HOLD_CAL_TICKS = HOLD_CAL_MS / TICK_TIME_MS;
   localparam int REFRESH_TICKS = REFRESH_MS / TICK_TIME_MS;

   // ==========================================================
   // count scaling and loop current span (microamps)
   localparam int GAIN_PERMIL = 1024;
   localparam int FS_COUNT_45 = 20000;
   localparam int FS_COUNT_35 = 2000;
   localparam int RANGE_GAIN = 10;
   localparam int SPAN_UA = 16000;
   localparam int OFFSET_UA = 4000;
   localparam int MID_UA = SPAN_UA / 2;
   localparam int RATIO_W = 24;
   localparam int COUNT_W = 20;

   // ==========================================================
   // register map (byte addresses) and control bit position
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] STATUS_OFS = 8'h04;
   localparam logic [7:0] RESULT_OFS = 8'h08;
   localparam logic [7:0] DISPLAY_OFS = 8'h0c;
   localparam logic [7:0] PEAK_OFS = 8'h10;
   localparam logic [7:0] OUTPUT_OFS = 8'h14;
   localparam int CTRL_CAL_BIT = 0;

   // sequencer states, one-hot
   typedef enum logic [2:0] {
      ST_WAIT = 3'b001,
      ST_CAL = 3'b010,
      ST_CONV = 3'b100
   } pmsq_state_t;
endpackage

// *** src/pmsq_scale.sv ***
// result scaling: signed count, dac code and loop current in microamps
// assumes ratio_in is input over reference, signed, two integer bits
`timescale 1ns/100ps
module pmsq_scale #(
   parameter int FS_COUNT = pmsq_pkg::FS_COUNT_45,
   parameter int RATIO_W = pmsq_pkg::RATIO_W,
   parameter int COUNT_W = pmsq_pkg::COUNT_W
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // new ratio and straps
   input wire logic valid_in,
   input wire logic signed [RATIO_W-1:0] ratio_in,
   input wire logic range_hi_in,
   input wire logic bipolar_in,
   input wire logic offset_en_in,
   // scaled results
   output logic valid_out,
   output logic signed [COUNT_W-1:0] count_out,
   output logic [15:0] dac_out,
   output logic [15:0] current_ua_out
);
   localparam int FRAC = RATIO_W - 2;
   localparam int MULT = pmsq_pkg::GAIN_PERMIL * FS_COUNT / 1000;
   localparam int MULT_HI = MULT * pmsq_pkg::RANGE_GAIN;

   logic signed [19:0] mult_sel;
   logic signed [RATIO_W+19:0] prod;
   logic signed [COUNT_W-1:0] count_next;
   int cnt, clamped, cur, dac;

   // count = 1.024 * ratio * full scale, ten times in the fine range
   assign mult_sel = range_hi_in ? 20'(MULT_HI) : 20'(MULT);
   assign prod = ratio_in * mult_sel;
   // negative inputs get one count added
   assign count_next = COUNT_W'(prod >>> FRAC) + ((ratio_in < 0) ? 20'sh1 : 20'sh0);

   // span mapping: unipolar clamps negatives to the span floor
   always_comb begin
      cnt = int'(count_next);
      clamped = cnt;
      if (clamped > FS_COUNT) begin
         clamped = FS_COUNT;
      end
      if (!bipolar_in && clamped < 0) begin
         clamped = 0;
      end
      if (bipolar_in && clamped < -FS_COUNT) begin
         clamped = -FS_COUNT;
      end
      if (bipolar_in) begin
         // zero input lands at midscale
         cur = pmsq_pkg::MID_UA + (pmsq_pkg::MID_UA * clamped) / FS_COUNT;
         dac = cnt + FS_COUNT - 1;
      end else begin
         cur = (pmsq_pkg::SPAN_UA * clamped) / FS_COUNT;
         dac = (cnt < 0) ? 0 : cnt;
      end
      if (offset_en_in) begin
         cur = cur + pmsq_pkg::OFFSET_UA; // 4-20 span, else 0-16
      end
      if (dac > 65535) begin
         dac = 65535;
      end
      if (dac < 0) begin
         dac = 0;
      end
   end

   // outputs registered once per conversion result
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         valid_out <= 1'b0;
         count_out <= '0;
         dac_out <= 16'h0000;
         current_ua_out <= 16'h0000;
      end else begin
         valid_out <= valid_in;
         if (valid_in) begin
            count_out <= count_next; // two's complement count
            dac_out <= 16'(dac);
            current_ua_out <= 16'(cur);
         end
      end
   end
endmodule

// *** src/pmsq_top.sv ***
// panel meter sequencer: power-up sequence, calibration, peak, hold,
// display refresh and an apb register window
// assumes synchronous inputs, one 100 MHz clock, apb master on the same clock
//
// How it works
// - filter and modulator held reset first
// - wait six seconds for reference settling
// - no reference by then: calibrate anyway
// - two second enhanced calibration, then convert
// - ordinary offset calibration every conversion cycle
// - hold high over two seconds recalibrates
// - peak start loads current result
// - larger result replaces the stored peak
// - smaller result leaves peak unchanged
// - peak low clears peak, disables detection
// - hold freezes the displayed reading
// - result kept as signed two's complement
// - offset enable picks 4-20 or 0-16
// - unipolar maps positive input to span
// - unipolar negatives clamp to span minimum
// - bipolar maps signed input, zero midscale
// - fine range scales count by ten
// - long variant count uses twenty thousand
// - short variant count uses two thousand
// - reference source follows internal select
// - dac buffer off when disable high
// - display priority hold, peak, latest
// - display refreshed at two and half hertz
//
// Design decisions made here: the address map and register access over APB.
`timescale 1ns/100ps
module pmsq_top #(
   parameter int FS_COUNT = pmsq_pkg::FS_COUNT_45,
   parameter int TICK_CYCLES = pmsq_pkg::TICK_CYCLES,
   parameter int REF_WAIT_TICKS = pmsq_pkg::REF_WAIT_TICKS,
   parameter int ENH_CAL_TICKS = pmsq_pkg::ENH_CAL_TICKS,
   parameter int HOLD_CAL_TICKS = pmsq_pkg::HOLD_CAL_TICKS,
   parameter int REFRESH_TICKS = pmsq_pkg::REFRESH_TICKS
) (
   // clock and power-on reset
   input wire logic CLK_IN,
   input wire logic RST_N_IN,
   // apb slave
   input wire logic PSEL_IN,
   input wire logic PENABLE_IN,
   input wire logic PWRITE_IN,
   input wire logic [7:0] PADDR_IN,
   input wire logic [31:0] PWDATA_IN,
   output logic [31:0] PRDATA_OUT,
   output logic PREADY_OUT,
   output logic PSLVERR_OUT,
   // front panel switches and straps
   input wire logic HOLD_IN,
   input wire logic PEAK_IN,
   input wire logic CURRENT_OFFSET_EN_IN,
   input wire logic BIPOLAR_SELECT_IN,
   input wire logic RANGE_HIGH_SENS_IN,
   input wire logic INTERNAL_REF_SELECT_IN,
   input wire logic DAC_REF_BUFFER_DISABLE_IN,
   // converter side
   input wire logic REF_VALID_IN,
   input wire logic RESULT_VALID_IN,
   input wire logic signed [pmsq_pkg::RATIO_W-1:0] RATIO_IN,
   // converter controls
   output logic FILTER_RESET_OUT,
   output logic ENH_CAL_OUT,
   output logic OFFSET_CAL_OUT,
   output logic CONV_RUN_OUT,
   output logic INTERNAL_REF_SELECT_OUT,
   output logic DAC_REF_BUFFER_EN_OUT,
   output logic CURRENT_OFFSET_EN_OUT,
   // readings
   output logic signed [pmsq_pkg::COUNT_W-1:0] DISPLAY_OUT,
   output logic [15:0] DAC_VOLTAGE_OUT,
   output logic [15:0] LOOP_CURRENT_OUT
);
   localparam int CW = pmsq_pkg::COUNT_W;
   localparam int TW = pmsq_pkg::TICK_CNT_W;

   // ==========================================================
   // declarations
   pmsq_pkg::pmsq_state_t state_reg, state_next;
   logic [pmsq_pkg::TICK_DIV_W-1:0] div_reg;
   logic [TW-1:0] phase_cnt_reg, hold_cnt_reg, refresh_cnt_reg;
   logic tick;
   logic phase_done, refresh_tick, hold_trig, sw_cal, recal_req;
   logic ref_seen_reg, ref_timeout_reg, ocal_reg;
   logic hold_q_reg, peak_act_reg, peak_rise, hold_rise;
   logic bip_reg, range_reg, ioff_reg, iref_reg, bufdis_reg;
   logic signed [CW-1:0] peak_reg, peak_next, held_reg, disp_reg, disp_sel;
   logic sc_valid;
   logic signed [CW-1:0] sc_count;
   logic [15:0] sc_dac, sc_cur;
   logic apb_wr, apb_rd_any, hit_ctrl, hit_stat, hit_res, hit_disp, hit_peak, hit_outp;
   logic [31:0] status_word;

   // ==========================================================
   // 1 ms tick divider; every slow time counts these pulses
   assign tick = (div_reg == pmsq_pkg::TICK_DIV_W'(TICK_CYCLES - 1));

   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN || tick) begin
         div_reg <= '0;
      end else begin
         div_reg <= div_reg + 1'b1;
      end
   end

   // ==========================================================
   // power-up sequencer
   assign phase_done = tick && (phase_cnt_reg == TW'(
      (state_reg == pmsq_pkg::ST_WAIT) ? REF_WAIT_TICKS - 1 : ENH_CAL_TICKS - 1));
   assign recal_req = hold_trig || sw_cal;

   // wait runs its full window whether or not a reference shows up
   always_comb begin
      case (state_reg)
         pmsq_pkg::ST_WAIT: begin
            state_next = phase_done ? pmsq_pkg::ST_CAL : pmsq_pkg::ST_WAIT;
         end
         pmsq_pkg::ST_CAL: begin
            state_next = phase_done ? pmsq_pkg::ST_CONV : pmsq_pkg::ST_CAL;
         end
         pmsq_pkg::ST_CONV: begin
            state_next = recal_req ? pmsq_pkg::ST_CAL : pmsq_pkg::ST_CONV;
         end
         default: begin
            state_next = pmsq_pkg::ST_WAIT;
         end
      endcase
   end

   // state and phase counter; counter restarts on every state change
   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN) begin
         state_reg <= pmsq_pkg::ST_WAIT;
         phase_cnt_reg <= '0;
      end else begin
         state_reg <= state_next;
         if (state_next != state_reg) begin
            phase_cnt_reg <= '0;
         end else if (tick && state_reg != pmsq_pkg::ST_CONV) begin
            phase_cnt_reg <= phase_cnt_reg + 1'b1;
         end
      end
   end

   // reference detection; timeout is sticky until the next power-on reset
   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN) begin
         ref_seen_reg <= 1'b0;
         ref_timeout_reg <= 1'b0;
      end else begin
         if (state_reg == pmsq_pkg::ST_WAIT && REF_VALID_IN) begin
            ref_seen_reg <= 1'b1;
         end
         if (state_reg == pmsq_pkg::ST_WAIT && phase_done && !ref_seen_reg
             && !REF_VALID_IN) begin
            ref_timeout_reg <= 1'b1;
         end
      end
   end

   // filter/modulator reset lasts the whole settling window
   assign FILTER_RESET_OUT = (state_reg == pmsq_pkg::ST_WAIT);
   assign ENH_CAL_OUT = (state_reg == pmsq_pkg::ST_CAL);
   assign CONV_RUN_OUT = (state_reg == pmsq_pkg::ST_CONV);
   assign OFFSET_CAL_OUT = ocal_reg;

   // one ordinary offset step per conversion, no request needed
   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN) begin
         ocal_reg <= 1'b0;
      end else begin
         ocal_reg <= CONV_RUN_OUT && RESULT_VALID_IN;
      end
   end

   // ==========================================================
   // hold-time measurement; fires once per press, then saturates
   assign hold_trig = HOLD_IN && tick && (hold_cnt_reg == TW'(HOLD_CAL_TICKS));

   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN || !HOLD_IN) begin
         hold_cnt_reg <= '0;
      end else if (tick && hold_cnt_reg <= TW'(HOLD_CAL_TICKS)) begin
         hold_cnt_reg <= hold_cnt_reg + 1'b1;
      end
   end

   // ==========================================================
   // straps sampled every cycle so a change is seen within one clock
   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN) begin
         bip_reg <= 1'b0;
         range_reg <= 1'b0;
         ioff_reg <= 1'b0;
         iref_reg <= 1'b0;
         bufdis_reg <= 1'b0;
      end else begin
         bip_reg <= BIPOLAR_SELECT_IN;
         range_reg <= RANGE_HIGH_SENS_IN;
         ioff_reg <= CURRENT_OFFSET_EN_IN;
         iref_reg <= INTERNAL_REF_SELECT_IN;
         bufdis_reg <= DAC_REF_BUFFER_DISABLE_IN;
      end
   end

   assign INTERNAL_REF_SELECT_OUT = iref_reg;
   assign DAC_REF_BUFFER_EN_OUT = !bufdis_reg;
   assign CURRENT_OFFSET_EN_OUT = ioff_reg;

   // ==========================================================
   // scaling; results only accepted while converting
   pmsq_scale #(
      .FS_COUNT(FS_COUNT),
      .RATIO_W(pmsq_pkg::RATIO_W),
      .COUNT_W(CW)
   ) u_scale (
      .clk_in(CLK_IN),
      .rst_n_in(RST_N_IN),
      .valid_in(RESULT_VALID_IN && CONV_RUN_OUT),
      .ratio_in(RATIO_IN),
      .range_hi_in(range_reg),
      .bipolar_in(bip_reg),
      .offset_en_in(ioff_reg),
      .valid_out(sc_valid),
      .count_out(sc_count),
      .dac_out(sc_dac),
      .current_ua_out(sc_cur)
   );

   assign DAC_VOLTAGE_OUT = sc_dac;
   assign LOOP_CURRENT_OUT = sc_cur;

   // ==========================================================
   // peak detection; equal results do not count as larger
   assign peak_rise = PEAK_IN && !peak_act_reg;
   assign hold_rise = HOLD_IN && !hold_q_reg;

   always_comb begin
      if (!PEAK_IN) begin
         peak_next = '0;
      end else if (peak_rise) begin
         peak_next = sc_count;
      end else if (sc_valid && sc_count > peak_reg) begin
         peak_next = sc_count;
      end else begin
         peak_next = peak_reg;
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN) begin
         peak_reg <= '0;
         peak_act_reg <= 1'b0;
         hold_q_reg <= 1'b0;
      end else begin
         peak_reg <= peak_next;
         peak_act_reg <= PEAK_IN;
         hold_q_reg <= HOLD_IN;
      end
   end

   // ==========================================================
   // display: priority select, slow refresh, frozen while hold is high
   assign disp_sel = hold_q_reg ? held_reg : (peak_act_reg ? peak_reg : sc_count);
   assign refresh_tick = tick && (refresh_cnt_reg == TW'(REFRESH_TICKS - 1));
   assign DISPLAY_OUT = disp_reg;

   // blocking the refresh during hold keeps the reading steady even
   // in the cycle where hold first rises
   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN) begin
         refresh_cnt_reg <= '0;
         disp_reg <= '0;
         held_reg <= '0;
      end else begin
         if (tick) begin
            refresh_cnt_reg <= refresh_tick ? '0 : refresh_cnt_reg + 1'b1;
         end
         if (refresh_tick && !HOLD_IN) begin
            disp_reg <= disp_sel;
         end
         if (hold_rise) begin
            held_reg <= disp_reg;
         end
      end
   end

   // ==========================================================
   // apb slave: zero wait states, error on unmapped addresses
   assign apb_wr = PSEL_IN && PENABLE_IN && PWRITE_IN;
   assign apb_rd_any = hit_ctrl || hit_stat || hit_res || hit_disp || hit_peak || hit_outp;
   assign hit_ctrl = (PADDR_IN == pmsq_pkg::CTRL_OFS);
   assign hit_stat = (PADDR_IN == pmsq_pkg::STATUS_OFS);
   assign hit_res = (PADDR_IN == pmsq_pkg::RESULT_OFS);
   assign hit_disp = (PADDR_IN == pmsq_pkg::DISPLAY_OFS);
   assign hit_peak = (PADDR_IN == pmsq_pkg::PEAK_OFS);
   assign hit_outp = (PADDR_IN == pmsq_pkg::OUTPUT_OFS);
   assign sw_cal = apb_wr && hit_ctrl && PWDATA_IN[pmsq_pkg::CTRL_CAL_BIT];
   assign status_word = {24'h000000, FILTER_RESET_OUT, hold_q_reg, peak_act_reg,
      ref_timeout_reg, ref_seen_reg, state_reg};
   assign PREADY_OUT = 1'b1;
   assign PSLVERR_OUT = PSEL_IN && PENABLE_IN && !apb_rd_any;

   // read mux; the calibration bit is self clearing and reads zero
   assign PRDATA_OUT = hit_stat ? status_word :
      hit_res ? 32'(sc_count) :
      hit_disp ? 32'(disp_reg) :
      hit_peak ? 32'(peak_reg) :
      hit_outp ? {sc_cur, sc_dac} : 32'h00000000;

   // ==========================================================
   // checks
   default clocking cb @(posedge CLK_IN); endclocking
   default disable iff (!RST_N_IN);

   a_filt_before_run: assert property (FILTER_RESET_OUT |=> !CONV_RUN_OUT)
      else $error("conversion ran straight out of filter reset");
   a_wait_length: assert property ($fell(FILTER_RESET_OUT) |-> ENH_CAL_OUT
      && $past(phase_cnt_reg) == TW'(REF_WAIT_TICKS - 1) && $past(tick))
      else $error("settling window ended at the wrong time");
   a_timeout_flag: assert property ((FILTER_RESET_OUT && phase_done
      && !ref_seen_reg && !REF_VALID_IN) |=> ref_timeout_reg && ENH_CAL_OUT)
      else $error("reference timeout not flagged");
   a_cal_length: assert property ($rose(CONV_RUN_OUT) |-> $past(ENH_CAL_OUT)
      && $past(phase_cnt_reg) == TW'(ENH_CAL_TICKS - 1))
      else $error("conversion began before calibration finished");
   a_ocal_each: assert property ((CONV_RUN_OUT && RESULT_VALID_IN) |=> OFFSET_CAL_OUT)
      else $error("no offset step after a conversion");
   a_hold_recal: assert property ((CONV_RUN_OUT && hold_trig) |=> ENH_CAL_OUT
      ##0 $past(hold_cnt_reg) == TW'(HOLD_CAL_TICKS))
      else $error("long hold did not recalibrate");
   a_peak_load: assert property (peak_rise |=> peak_reg == $past(sc_count))
      else $error("peak start did not load the result");
   a_peak_grow: assert property ((peak_act_reg && PEAK_IN && sc_valid
      && sc_count > peak_reg) |=> peak_reg == $past(sc_count))
      else $error("larger result did not replace peak");
   a_peak_keep: assert property ((peak_act_reg && PEAK_IN && sc_valid
      && sc_count <= peak_reg) |=> $stable(peak_reg))
      else $error("smaller or equal result changed peak");
   a_peak_clear: assert property (!PEAK_IN |=> peak_reg == '0 && !peak_act_reg)
      else $error("peak not cleared");
   a_hold_freeze: assert property (HOLD_IN [*2] |=> $stable(DISPLAY_OUT))
      else $error("display moved during hold");
   a_disp_prio: assert property ((refresh_tick && !HOLD_IN && !hold_q_reg
      && peak_act_reg) |=> DISPLAY_OUT == $past(peak_reg))
      else $error("peak not shown when selected");
   a_disp_rate: assert property ((!refresh_tick) |=> $stable(DISPLAY_OUT))
      else $error("display changed off the refresh tick");

   c_run: cover property ($rose(CONV_RUN_OUT));
   c_timeout: cover property ($rose(ref_timeout_reg));
   c_recal: cover property (CONV_RUN_OUT && hold_trig);
   c_peak_up: cover property (peak_act_reg && sc_valid && sc_count > peak_reg);
endmodule

// *** bench/pmsq_conv_model.sv ***
// converter result source standing on the far side of the sequencer
// assumes the bench raises send_in one cycle ahead of the wanted pulse
`timescale 1ns/100ps
module pmsq_conv_model (
   // clock
   input wire logic clk_in,
   // request from the bench
   input wire logic send_in,
   input wire logic ref_in,
   input wire logic signed [pmsq_pkg::RATIO_W-1:0] val_in,
   // converter side
   output logic ref_valid_out,
   output logic result_valid_out,
   output logic signed [pmsq_pkg::RATIO_W-1:0] ratio_out
);
   // ==========================================================
   // result pulse
   // the bench decides whether a settled reference is reported, so both the
   // timeout and the seen path of the settling window get exercised
   assign ref_valid_out = ref_in;
   // between pulses the ratio is stale: invert it on every clock so nothing leans on it
   always @(posedge clk_in) begin
      result_valid_out <= send_in;
      ratio_out <= send_in ? val_in : ~ratio_out;
   end
   initial begin
      result_valid_out = 1'b0;
      ratio_out = 24'h000000;
   end
endmodule

// *** bench/panel_meter_sequencer_tb.sv ***
// self-checking bench for the panel meter sequencer
// assumes shortened tick counts and the converter model on the result inputs
`timescale 1ns/100ps
module panel_meter_sequencer_tb;
   // ==========================================================
   // stimulus and observation
   localparam longint FS = pmsq_pkg::FS_COUNT_45;
   logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
   logic hold = 1'b0, peak = 1'b0, off_en = 1'b0, bip = 1'b0, rng = 1'b0;
   logic iref = 1'b0, bufdis = 1'b0, send = 1'b0, refv = 1'b0, err, ref_v, res_v;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000, rd, prdata;
   logic signed [23:0] rval = 24'h000000, ratio;
   logic pready, pslverr, f_rst, enh, ocal, run, iref_o, buf_en, off_o;
   logic signed [19:0] disp;
   logic [15:0] dac, cur;
   int err_count = 0, compares = 0, cyc = 0, ocal_n = 0, n;
   always #5 clk = ~clk;
   pmsq_conv_model conv (.clk_in(clk), .send_in(send), .ref_in(refv), .val_in(rval),
      .ref_valid_out(ref_v), .result_valid_out(res_v), .ratio_out(ratio));
   pmsq_top #(.TICK_CYCLES(10), .REF_WAIT_TICKS(6), .ENH_CAL_TICKS(4),
      .HOLD_CAL_TICKS(3), .REFRESH_TICKS(2)) dut (.CLK_IN(clk), .RST_N_IN(rst_n),
      .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr),
      .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
      .HOLD_IN(hold), .PEAK_IN(peak), .CURRENT_OFFSET_EN_IN(off_en),
      .BIPOLAR_SELECT_IN(bip), .RANGE_HIGH_SENS_IN(rng), .INTERNAL_REF_SELECT_IN(iref),
      .DAC_REF_BUFFER_DISABLE_IN(bufdis), .REF_VALID_IN(ref_v), .RESULT_VALID_IN(res_v),
      .RATIO_IN(ratio), .FILTER_RESET_OUT(f_rst), .ENH_CAL_OUT(enh), .OFFSET_CAL_OUT(ocal),
      .CONV_RUN_OUT(run), .INTERNAL_REF_SELECT_OUT(iref_o), .DAC_REF_BUFFER_EN_OUT(buf_en),
      .CURRENT_OFFSET_EN_OUT(off_o), .DISPLAY_OUT(disp), .DAC_VOLTAGE_OUT(dac),
      .LOOP_CURRENT_OUT(cur));
   // offset pulses are one cycle wide, so count them at every edge
   always @(posedge clk) if (ocal === 1'b1) ocal_n++;
   // hang guard: the whole run needs well under a thousand cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 4000) begin
         err_count++;
         end_sim();
      end
   end
   // ==========================================================
   // shared tasks and expectations
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      // only the hang guard ends a wait for the answer
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   task automatic wait_hi(input bit cv, input int lim, output int k);
      k = 0;
      while ((cv ? run : enh) !== 1'b1 && k < lim) begin
         @(posedge clk);
         k++;
      end
   endtask
   task automatic put(input logic signed [23:0] r);
      @(posedge clk);
      send <= 1'b1;
      rval <= r;
      @(posedge clk);
      send <= 1'b0;
      repeat (3) @(posedge clk);
   endtask
   // result, then one full refresh period before the display is judged
   task automatic pd(input logic signed [23:0] r, input logic [31:0] e);
      put(r);
      repeat (25) @(posedge clk);
      chk(disp, e);
   endtask
   function automatic longint ecnt(input longint r, input bit hi);
      longint v;
      v = (r * pmsq_pkg::GAIN_PERMIL * FS / 1000 * (hi ? 10 : 1)) >>> 22;
      return v + (r < 0 ? 1 : 0);
   endfunction
   function automatic longint ecur(input longint c, input bit b, input bit o);
      longint s;
      if (b) s = pmsq_pkg::MID_UA + pmsq_pkg::MID_UA * (c > FS ? FS : c < -FS ? -FS : c) / FS;
      else s = pmsq_pkg::SPAN_UA * (c > FS ? FS : c < 0 ? 0 : c) / FS;
      return s + (o ? pmsq_pkg::OFFSET_UA : 0);
   endfunction
   // dac code: unipolar floors at zero, bipolar shifts by full scale less one
   function automatic longint edac(input longint c, input bit b);
      longint v;
      v = b ? c + FS - 1 : (c < 0 ? 0 : c);
      return v > 65535 ? 65535 : (v < 0 ? 0 : v);
   endfunction
   task automatic end_sim();
      if (err_count == 0 && compares > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // ==========================================================
   // scenarios
   task automatic t_map();
      // {range, bipolar, offset} per case, both spans and both unipolar clamp corners, neither bipolar clamp
      logic [2:0] cf [8] = '{3'b001, 3'b000, 3'b001, 3'b000, 3'b011, 3'b010, 3'b101, 3'b000};
      int rs [8] = '{2097152, 2097152, -2097152, -2097152, 0, 2097152, 524288, 4194304};
      int c;
      for (int i = 0; i < 8; i++) begin
         @(posedge clk);
         {rng, bip, off_en} <= cf[i];
         c = ocal_n;
         put(rs[i]);
         chk(cur, ecur(ecnt(rs[i], cf[i][2]), cf[i][1], cf[i][0]));
         chk(dac, edac(ecnt(rs[i], cf[i][2]), cf[i][1]));
         chk(off_o, cf[i][0]);
         chk(ocal_n, c + 1);
         apb(1'b0, pmsq_pkg::RESULT_OFS, 32'h0);
         chk(rd, ecnt(rs[i], cf[i][2]));
      end
   endtask
   task automatic t_peak();
      put(24'sh200000);
      peak <= 1'b1;
      repeat (25) @(posedge clk);
      chk(disp, ecnt(2097152, 0));
      pd(24'sh100000, ecnt(2097152, 0));
      pd(24'sh300000, ecnt(3145728, 0));
      put(24'sh300000);
      apb(1'b0, pmsq_pkg::PEAK_OFS, 32'h0);
      chk(rd, ecnt(3145728, 0));
      put(24'sh100000);
      peak <= 1'b0;
      repeat (25) @(posedge clk);
      chk(disp, ecnt(1048576, 0));
      apb(1'b0, pmsq_pkg::PEAK_OFS, 32'h0);
      chk(rd, 32'h0);
   endtask
   task automatic t_hold();
      pd(24'sh200000, ecnt(2097152, 0));
      hold <= 1'b1;
      pd(24'sh100000, ecnt(2097152, 0));
      wait_hi(1'b0, 80, n);
      chk(n < 80, 1'b1);
      hold <= 1'b0;
      wait_hi(1'b1, 80, n);
      chk(n >= 30 && n <= 45, 1'b1);
      apb(1'b1, pmsq_pkg::CTRL_OFS, 32'h1);
      @(posedge clk);
      chk(enh, 1'b1);
      wait_hi(1'b1, 80, n);
      chk(n >= 30 && n <= 45, 1'b1);
      apb(1'b0, 8'h20, 32'h0);
      chk(err, 1'b1);
      chk(rd, 32'h0);
   endtask
   // mid-run reset with the reference reported: full window, no timeout
   task automatic t_rst();
      refv <= 1'b1;
      rst_n <= 1'b0;
      repeat (10) @(posedge clk);
      chk({f_rst, run, disp}, 22'h200000);
      rst_n <= 1'b1;
      wait_hi(1'b0, 200, n);
      chk(n >= 50 && n <= 75, 1'b1);
      apb(1'b0, pmsq_pkg::STATUS_OFS, 32'h0);
      chk(rd[4:3], 2'b01);
   endtask
   // ==========================================================
   // main sequence
   initial begin
      repeat (10) @(posedge clk);
      chk({f_rst, run}, 2'b10);
      rst_n <= 1'b1;
      wait_hi(1'b0, 200, n);
      chk(n >= 50 && n <= 75, 1'b1);
      wait_hi(1'b1, 80, n);
      chk(n >= 30 && n <= 45, 1'b1);
      apb(1'b0, pmsq_pkg::STATUS_OFS, 32'h0);
      chk(rd[4], 1'b1);
      for (int v = 1; v >= 0; v--) begin
         iref <= v[0];
         bufdis <= v[0];
         repeat (2) @(posedge clk);
         chk({iref_o, buf_en}, {v[0], ~v[0]});
      end
      t_map();
      t_peak();
      t_hold();
      t_rst();
      end_sim();
   end
endmodule
